//--- hdl/smm_pkg.sv
package smm_pkg;
	// ****************************************************************
	// Register byte addresses
	// ****************************************************************
	localparam logic [7:0] SMM_DIV_LOWER_ADDR = 8'h00;
	localparam logic [7:0] SMM_DIV_UPPER_ADDR = 8'h04;
	localparam logic [7:0] SMM_SETUP_ADDR = 8'h08;
	localparam logic [7:0] SMM_OUT_BYTE_ADDR = 8'h0c;
	localparam logic [7:0] SMM_IN_BYTE_ADDR = 8'h0c;
	localparam logic [7:0] SMM_CMD_ADDR = 8'h10;
	localparam logic [7:0] SMM_FLAGS_ADDR = 8'h10;
	localparam logic [7:0] SMM_IRQ_STAT_ADDR = 8'h14;
	localparam logic [7:0] SMM_IRQ_EN_ADDR = 8'h18;
	localparam logic [7:0] SMM_IRQ_CLR_ADDR = 8'h1c;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int SMM_SETUP_EN = 7;
	localparam int SMM_SETUP_IEN = 6;
	localparam int SMM_CMD_START = 7;
	localparam int SMM_CMD_STOP = 6;
	localparam int SMM_CMD_READ = 5;
	localparam int SMM_CMD_WRITE = 4;
	localparam int SMM_CMD_NACK = 3;
	localparam int SMM_CMD_ERRCLR = 2;
	localparam int SMM_CMD_DONECLR = 0;
	localparam int SMM_FL_DONE = 0;
	localparam int SMM_FL_ERR = 1;
	localparam int SMM_FL_ARB = 2;
	localparam int SMM_FL_NACK = 3;
	localparam int SMM_FL_XFER = 5;
	localparam int SMM_FL_BUSY = 6;
	localparam int SMM_IRQ_DONE = 0;
	localparam int SMM_IRQ_ERR = 1;

	// ****************************************************************
	// Reset values and counts
	// ****************************************************************
	localparam logic [7:0] SMM_DIV_RESET = 8'hff;
	localparam logic [7:0] SMM_ZERO8 = 8'h00;
	localparam logic [2:0] SMM_QUARTERS = 3'h5;

	// Bus phases, gray coded along start, bits, ack, stop
	typedef enum logic [3:0] {
		SMM_IDLE = 4'h0,
		SMM_STA_A = 4'h1,
		SMM_STA_B = 4'h3,
		SMM_BIT = 4'h2,
		SMM_ACK = 4'h6,
		SMM_STO_A = 4'h7,
		SMM_STO_B = 4'h5,
		SMM_DONE = 4'h4
	} smm_phase_e;
endpackage : smm_pkg

//--- hdl/smm_tick.sv
`timescale 1ns/100ps
// Quarter-bit tick generator; the bit engine uses five ticks per bit
module smm_tick (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic run,
	input wire logic [15:0] prescale,
	// Tick out
	output logic tick
);
	import smm_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} smm_tick_s;

	smm_tick_s st;
	smm_tick_s next_st;

	// Count down prescale cycles per tick; zero behaves as one
	always_comb
	begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!run)
			next_st.cnt = 16'h0000;
		else if (st.cnt <= 16'h0001)
		begin
			next_st.cnt = prescale;
			next_st.tick = 1'b1;
		end
		else
			next_st.cnt = st.cnt - 16'h0001;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign tick = st.tick;
endmodule : smm_tick

//--- hdl/smm_master.sv
`timescale 1ns/100ps
//
// Function
// - 0x80 to setup enables controller; 0xc0 also enables interrupt.
// - Command 0x90 makes start then transmits outgoing byte.
// - Command 0x10 transmits outgoing byte without new start.
// - Command 0x40 generates stop, ending the transaction.
// - 0x20 receives and acknowledges a byte; 0x28 receives and nacks.
// - Completion sets flag bit 0 and interrupt when enabled.
// - Writing 0x1 to command clears flag bit 0.
// - Flag bit 6 is high while another master uses the bus.
// - Writing 0x5 to command clears flag bits 0 to 3 (done and the error flags).
// - Received byte appears in the incoming byte register.
// - Serial clock is system clock over five times prescale.
// - Slave logic is halted while the master runs a transfer.
//
module smm_master (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Two-wire bus, output enable low means pull low
	input wire logic scl_in,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_oe_n,
	// System
	output logic irq,
	output logic slave_halt
);
	import smm_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [7:0] div_lower;
		logic [7:0] div_upper;
		logic [7:0] setup;
		logic [7:0] out_byte;
		logic [7:0] in_byte;
		logic [7:0] cmd;
		logic [7:0] flags;
		logic [1:0] irq_stat;
		logic [1:0] irq_en;
		smm_phase_e phase;
		logic [2:0] quarter;
		logic [3:0] bitn;
		logic [7:0] shift;
		logic rd;
		logic scl_oe_n;
		logic sda_oe_n;
		logic sda_prev;
		logic scl_prev;
		logic other_busy;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic halt;
	} smm_state_s;

	smm_state_s st;
	smm_state_s next_st;
	logic tick;
	logic access;
	logic wr;
	logic done_ev;
	logic err_ev;

	// Divider feeding the quarter ticks
	smm_tick u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.run(st.phase != SMM_IDLE),
		.prescale({st.div_upper, st.div_lower}),
		.tick(tick)
	);

	// True when the address names a mapped register
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == SMM_DIV_LOWER_ADDR) || (a == SMM_DIV_UPPER_ADDR)
			|| (a == SMM_SETUP_ADDR) || (a == SMM_OUT_BYTE_ADDR)
			|| (a == SMM_CMD_ADDR) || (a == SMM_IRQ_STAT_ADDR)
			|| (a == SMM_IRQ_EN_ADDR) || (a == SMM_IRQ_CLR_ADDR);
	endfunction : mapped

	// Zero-extend a byte to the bus width
	function automatic logic [31:0] word(input logic [7:0] b);
		word = {24'h000000, b};
	endfunction : word

	assign access = psel && penable && !st.pready;
	assign wr = access && pwrite && mapped(paddr);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		next_st = st;
		done_ev = 1'b0;
		err_ev = 1'b0;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		next_st.sda_prev = sda_in;
		next_st.scl_prev = scl_in;

		// Foreign start and stop seen while we are idle
		if (st.phase == SMM_IDLE && st.scl_prev && scl_in)
		begin
			if (st.sda_prev && !sda_in)
				next_st.other_busy = 1'b1;
			else if (!st.sda_prev && sda_in)
				next_st.other_busy = 1'b0;
		end
		next_st.flags[SMM_FL_BUSY] = next_st.other_busy;
		// Running drops as done rises, so software never sees both
		next_st.flags[SMM_FL_XFER] = (st.phase != SMM_IDLE)
			&& (st.phase != SMM_DONE);

		// Bit engine, five quarters per bit
		if (tick)
		begin
			next_st.quarter = (st.quarter == SMM_QUARTERS - 3'h1) ?
				3'h0 : st.quarter + 3'h1;
			case (st.phase)
				SMM_STA_A:
				begin
					next_st.sda_oe_n = 1'b1;
					next_st.scl_oe_n = 1'b1;
					if (st.quarter == SMM_QUARTERS - 3'h1)
						next_st.phase = SMM_STA_B;
				end
				SMM_STA_B:
				begin
					next_st.sda_oe_n = 1'b0;
					if (st.quarter == SMM_QUARTERS - 3'h1)
					begin
						next_st.scl_oe_n = 1'b0;
						next_st.phase = SMM_BIT;
						next_st.bitn = 4'h0;
					end
				end
				SMM_BIT, SMM_ACK:
				begin
					if (st.quarter == 3'h0)
					begin
						if (st.phase == SMM_ACK)
							next_st.sda_oe_n = st.rd ?
								st.cmd[SMM_CMD_NACK] : 1'b1;
						else
							next_st.sda_oe_n = st.rd ? 1'b1 : st.shift[7];
					end
					else if (st.quarter == 3'h1)
						next_st.scl_oe_n = 1'b1;
					else if (st.quarter == 3'h2 && !scl_in)
						next_st.quarter = 3'h2; // Slave stretches
					else if (st.quarter == 3'h3)
					begin
						if (st.phase == SMM_BIT)
						begin
							if (!st.rd && st.sda_oe_n && !sda_in)
							begin
								next_st.flags[SMM_FL_ARB] = 1'b1;
								err_ev = 1'b1;
								next_st.sda_oe_n = 1'b1;
								next_st.scl_oe_n = 1'b1;
								next_st.phase = SMM_DONE;
							end
							next_st.shift = {st.shift[6:0], sda_in};
						end
						else if (!st.rd && sda_in)
						begin
							next_st.flags[SMM_FL_NACK] = 1'b1;
							err_ev = 1'b1;
						end
					end
					else if (st.quarter == 3'h4)
					begin
						next_st.scl_oe_n = 1'b0;
						if (st.phase == SMM_ACK)
							next_st.phase = SMM_DONE;
						else if (st.bitn == 4'h7)
							next_st.phase = SMM_ACK;
						else
							next_st.bitn = st.bitn + 4'h1;
					end
				end
				SMM_STO_A:
				begin
					next_st.sda_oe_n = 1'b0;
					if (st.quarter == 3'h2)
						next_st.scl_oe_n = 1'b1;
					if (st.quarter == SMM_QUARTERS - 3'h1)
						next_st.phase = SMM_STO_B;
				end
				SMM_STO_B:
				begin
					next_st.sda_oe_n = 1'b1;
					if (st.quarter == SMM_QUARTERS - 3'h1)
						next_st.phase = SMM_DONE;
				end
				default:
				begin
					next_st.quarter = st.quarter;
				end
			endcase
		end

		// Finish: latch byte, flag completion, drop the requests
		if (st.phase == SMM_DONE)
		begin
			if (st.rd)
				next_st.in_byte = st.shift;
			next_st.flags[SMM_FL_DONE] = 1'b1;
			done_ev = 1'b1;
			next_st.cmd = 8'h00;
			next_st.phase = SMM_IDLE;
		end

		// Launch one pending request; start outranks stop
		if (st.phase == SMM_IDLE && st.setup[SMM_SETUP_EN])
		begin
			next_st.quarter = 3'h0;
			next_st.bitn = 4'h0;
			if (st.cmd[SMM_CMD_START] && st.cmd[SMM_CMD_WRITE])
			begin
				next_st.phase = SMM_STA_A;
				next_st.rd = 1'b0;
				next_st.shift = st.out_byte;
				next_st.other_busy = 1'b0;
			end
			else if (st.cmd[SMM_CMD_WRITE])
			begin
				next_st.phase = SMM_BIT;
				next_st.rd = 1'b0;
				next_st.shift = st.out_byte;
			end
			else if (st.cmd[SMM_CMD_READ])
			begin
				next_st.phase = SMM_BIT;
				next_st.rd = 1'b1;
				next_st.sda_oe_n = 1'b1;
			end
			else if (st.cmd[SMM_CMD_STOP])
				next_st.phase = SMM_STO_A;
		end
		// Slave side stays halted while we own the bus, scl held low too
		next_st.halt = (next_st.phase != SMM_IDLE)
			|| !next_st.scl_oe_n;

		// Register writes; a hardware set wins over a clear
		if (wr)
		begin
			case (paddr)
				SMM_DIV_LOWER_ADDR: next_st.div_lower = pwdata[7:0];
				SMM_DIV_UPPER_ADDR: next_st.div_upper = pwdata[7:0];
				SMM_SETUP_ADDR: next_st.setup = pwdata[7:0];
				SMM_OUT_BYTE_ADDR: next_st.out_byte = pwdata[7:0];
				SMM_CMD_ADDR:
				begin
					if (st.phase == SMM_IDLE)
						next_st.cmd = pwdata[7:0] &
							8'hf8;
					if (pwdata[SMM_CMD_DONECLR] && !done_ev)
						next_st.flags[SMM_FL_DONE] = 1'b0;
					// An error raised in this cycle survives
					if (pwdata[SMM_CMD_ERRCLR] && !err_ev)
					begin
						next_st.flags[SMM_FL_ERR] = 1'b0;
						next_st.flags[SMM_FL_ARB] = 1'b0;
						next_st.flags[SMM_FL_NACK] = 1'b0;
					end
				end
				SMM_IRQ_EN_ADDR: next_st.irq_en = pwdata[1:0];
				SMM_IRQ_CLR_ADDR:
					next_st.irq_stat = st.irq_stat & ~pwdata[1:0];
				default: next_st.irq_en = st.irq_en;
			endcase
		end
		if (err_ev)
			next_st.flags[SMM_FL_ERR] = 1'b1;
		if (done_ev)
			next_st.irq_stat[SMM_IRQ_DONE] = 1'b1;
		if (err_ev)
			next_st.irq_stat[SMM_IRQ_ERR] = 1'b1;
		next_st.irq = st.setup[SMM_SETUP_IEN] &&
			((next_st.flags[SMM_FL_DONE] &&
			st.setup[SMM_SETUP_EN]) ||
			|(next_st.irq_stat & next_st.irq_en));

		// Read data and the one-wait-state answer
		if (access)
		begin
			next_st.pready = 1'b1;
			next_st.pslverr = !mapped(paddr);
			next_st.prdata = 32'h00000000;
			if (!pwrite)
			begin
				case (paddr)
					SMM_DIV_LOWER_ADDR: next_st.prdata = word(st.div_lower);
					SMM_DIV_UPPER_ADDR: next_st.prdata = word(st.div_upper);
					SMM_SETUP_ADDR: next_st.prdata = word(st.setup);
					SMM_IN_BYTE_ADDR: next_st.prdata = word(st.in_byte);
					SMM_FLAGS_ADDR: next_st.prdata = word(st.flags);
					SMM_IRQ_STAT_ADDR:
						next_st.prdata = {30'h00000000, st.irq_stat};
					SMM_IRQ_EN_ADDR:
						next_st.prdata = {30'h00000000, st.irq_en};
					default: next_st.prdata = 32'h00000000;
				endcase
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.div_lower <= SMM_DIV_RESET;
			st.div_upper <= SMM_ZERO8;
			st.phase <= SMM_IDLE;
			st.scl_oe_n <= 1'b1;
			st.sda_oe_n <= 1'b1;
			st.sda_prev <= 1'b1;
			st.scl_prev <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign scl_oe_n = st.scl_oe_n;
	assign sda_oe_n = st.sda_oe_n;
	assign irq = st.irq;
	assign slave_halt = st.halt;
endmodule : smm_master

//--- verification/smm_slave_model.sv
`timescale 1ns/100ps
// ****
// Slave: acks its own address, returns rd_byte on reads
// ****
module smm_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	// Bus
	input wire logic pclk,
	input wire logic scl,
	input wire logic sda,
	output logic sda_oe_n,
	// Test side
	input wire logic [7:0] rd_byte,
	output logic [7:0] last_byte,
	output logic [7:0] n_start
);
	logic s1 = 1'b1;
	logic d1 = 1'b1;
	logic adr = 1'b0;
	logic rd = 1'b0;
	logic act = 1'b0;
	logic [3:0] n = 4'h0;
	logic [7:0] sh = 8'h00;
	// Released at time zero
	initial
	begin
		sda_oe_n = 1'b1;
		n_start = 8'h00;
	end
	// Edges seen on pclk; no clock stretching, so scl is never held
	always @(posedge pclk)
	begin
		s1 <= scl;
		d1 <= sda;
		if (scl && s1 && d1 && !sda)
		begin
			n <= 4'hf;
			adr <= 1'b1;
			n_start <= n_start + 8'h01;
			sda_oe_n <= 1'b1;
		end
		else if (scl && !s1)
			sh <= {sh[6:0], sda};
		else if (!scl && s1)
		begin
			n <= n[3] ? 4'h0 : n + 4'h1;
			if (n == 4'h7)
			begin
				last_byte <= sh;
				rd <= adr ? sh[0] : rd;
				act <= adr ? sh[7:1] == ADDR : act;
				// Ack only its address and bytes written to it
				sda_oe_n <= adr ? sh[7:1] != ADDR : !act || rd;
			end
			else if (n == 4'h8)
			begin
				adr <= 1'b0;
				// Next read byte only after the master acked
				sda_oe_n <= !(act && rd && !sh[0]) || rd_byte[7];
			end
			else if (!n[3])
				sda_oe_n <= !(act && rd && !adr) || rd_byte[3'h6 - n[2:0]];
		end
	end
endmodule : smm_slave_model

//--- verification/smm_master_sva.sv
`timescale 1ns/100ps
// ****
// Port checks of the master
// ****
module smm_master_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Two-wire side
	input wire logic scl_oe_n,
	input wire logic sda_oe_n,
	input wire logic slave_halt
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Exactly one wait state, one-cycle answer, only to a request
	a_ready_one_wait: assert property (psel && penable && !pready
		|=> pready) else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_req: assert property (pready |-> psel && penable)
		else $error("pready without request");
	// Error response tied to the address map
	a_unmapped_err: assert property (pready && paddr > 8'h1c |-> pslverr)
		else $error("unmapped address not refused");
	a_mapped_ok: assert property (pready && paddr < 8'h1c
		&& paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped refused");
	a_upper_zero: assert property (pready && !pwrite
		|-> prdata[31:8] == 24'h0) else $error("upper read bits set");
	// Slave side halted whenever the master holds the bus
	a_halt_scl: assert property (!scl_oe_n |-> slave_halt)
		else $error("scl driven while slave logic awake");
	a_idle_release: assert property (!slave_halt && $past(!slave_halt)
		|-> scl_oe_n && sda_oe_n) else $error("bus held");
	c_refused: cover property (pready && pslverr);
	c_scl_pulse: cover property (!scl_oe_n ##1 scl_oe_n);
	c_halt: cover property ($rose(slave_halt));
endmodule : smm_master_sva

bind smm_master smm_master_sva chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .scl_oe_n, .sda_oe_n,
	.slave_halt);

//--- verification/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin \
	n_mismatch++; $display("mismatch %s exp %h seen %h", nm, e, s); end end
module testbench;
	import smm_pkg::*;
	// ****
	// Bench state
	// ****
	localparam logic [6:0] SLV = 7'h2a;
	localparam logic [15:0] PRE = 16'h0002;
	localparam logic [7:0] CA = SMM_CMD_ADDR;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, rerr, irq, slave_halt, scl_oe_n, sda_oe_n;
	logic m_sda_n, eirq;
	logic ext_sda_n = 1'b1;
	logic scl_d = 1'b1;
	logic [7:0] rd_byte = 8'h00;
	logic [7:0] last_byte, n_start, s0, v;
	logic [15:0] cyc = 16'h0;
	logic [15:0] t_rise = 16'h0;
	logic [15:0] per = 16'h0;
	int n_mismatch = 0;
	int compares = 0;
	// Open-drain lines with pull-ups
	wire scl = scl_oe_n;
	wire sda = sda_oe_n & m_sda_n & ext_sda_n;
	smm_master dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .scl_oe_n,
		.sda_in(sda), .sda_oe_n, .irq, .slave_halt);
	smm_slave_model #(.ADDR(SLV)) pm (.pclk, .scl, .sda, .sda_oe_n(m_sda_n),
		.rd_byte, .last_byte, .n_start);
	always #2.5 pclk = ~pclk;
	// Scl period between rises, and the run's cycle ceiling
	always @(posedge pclk)
	begin
		cyc <= cyc + 16'h1;
		scl_d <= scl;
		if (scl && !scl_d)
		begin
			per <= cyc - t_rise;
			t_rise <= cyc;
		end
		if (cyc == 16'd30000)
		begin
			n_mismatch++;
			report_and_stop;
		end
	end
	function automatic logic [7:0] addr_byte(input logic r);
		return {SLV, r};
	endfunction : addr_byte
	// Waits for pready as long as it takes; only the cycle ceiling ends it
	task automatic apb(input logic w, input logic [7:0] a, input int d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// One command: load byte, issue, poll done, clear done
	task automatic xfer(input logic [7:0] c, tx, ef, em);
		int t;
		t = 0;
		apb(1'b1, SMM_OUT_BYTE_ADDR, tx);
		apb(1'b1, CA, c);
		do
			apb(1'b0, CA, 0);
		while (rdat[0] !== 1'b1 && t++ < 200);
		`CHK("flags", ef, rdat[7:0] & em)
		`CHK("irq", eirq, irq)
		apb(1'b1, CA, 1);
		apb(1'b0, CA, 0);
		`CHK("flags clear", ef & 8'hfe, rdat[7:0] & em)
		`CHK("irq clear", 1'b0, irq)
	endtask : xfer
	task report_and_stop;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	// Main sequence
	initial
	begin
		v = 8'($urandom(52));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, SMM_DIV_LOWER_ADDR, 0);
		`CHK("div reset", {24'h0, SMM_DIV_RESET}, rdat)
		apb(1'b0, 8'h40, 0);
		`CHK("unmapped", 1'b1, rerr)
		apb(1'b1, SMM_DIV_UPPER_ADDR, PRE[15:8]);
		apb(1'b1, SMM_DIV_LOWER_ADDR, PRE[7:0]);
		$display("test registers done");
		eirq = 1'b0;
		apb(1'b1, SMM_SETUP_ADDR, 8'h80);
		apb(1'b0, CA, 0);
		`CHK("idle flags", 32'h0, rdat)
		s0 = n_start;
		xfer(8'h90, addr_byte(1'b0), 8'h01, 8'hbf);
		`CHK("start", s0 + 8'h1, n_start)
		`CHK("address", addr_byte(1'b0), last_byte)
		repeat (3)
		begin
			v = 8'($urandom);
			xfer(8'h10, v, 8'h01, 8'hbf);
			`CHK("data", v, last_byte)
			`CHK("no start", s0 + 8'h1, n_start)
			`CHK("scl period", 5 * PRE, per)
		end
		xfer(8'h40, 8'h00, 8'h01, 8'hbf);
		`CHK("stop sda", 1'b1, sda)
		`CHK("halt", 1'b0, slave_halt)
		$display("test write done");
		eirq = 1'b1;
		rd_byte <= 8'($urandom);
		apb(1'b1, SMM_SETUP_ADDR, 8'hc0);
		xfer(8'h90, addr_byte(1'b1), 8'h01, 8'hbf);
		for (int i = 0; i < 2; i++)
		begin
			xfer(i ? 8'h28 : 8'h20, 8'h00, 8'h01, 8'hbf);
			apb(1'b0, SMM_IN_BYTE_ADDR, 0);
			`CHK("in byte", {24'h0, rd_byte}, rdat)
		end
		xfer(8'h40, 8'h00, 8'h01, 8'hbf);
		apb(1'b0, SMM_IRQ_STAT_ADDR, 0);
		`CHK("irq status", 1'b1, rdat[SMM_IRQ_DONE])
		apb(1'b1, SMM_IRQ_EN_ADDR, 1);
		`CHK("irq enabled", 1'b1, irq)
		apb(1'b1, SMM_IRQ_CLR_ADDR, 3);
		`CHK("irq cleared", 1'b0, irq)
		$display("test read done");
		eirq = 1'b0;
		apb(1'b1, SMM_SETUP_ADDR, 8'h80);
		xfer(8'h90, {~SLV, 1'b0}, 8'h09, 8'h09);
		apb(1'b1, CA, 5);
		apb(1'b0, CA, 0);
		`CHK("error clear", 32'h0, rdat & 32'hbf)
		xfer(8'h40, 8'h00, 8'h01, 8'hbf);
		$display("test error done");
		// Another driver holds sda low under our first address bit
		apb(1'b1, SMM_OUT_BYTE_ADDR, 8'hff);
		apb(1'b1, CA, 8'h90);
		wait (scl_oe_n === 1'b0);
		@(posedge pclk);
		ext_sda_n <= 1'b0;
		do
			apb(1'b0, CA, 0);
		while (rdat[0] !== 1'b1);
		`CHK("arbitration", 8'h07, rdat[7:0] & 8'h0f)
		`CHK("irq off", 1'b0, irq)
		apb(1'b1, CA, 5);
		ext_sda_n <= 1'b1;
		apb(1'b0, CA, 0);
		`CHK("arb clear", 32'h0, rdat & 32'hbf)
		$display("test arbitration done");
		ext_sda_n <= 1'b0;
		repeat (10) @(posedge pclk);
		apb(1'b0, CA, 0);
		`CHK("busy", 1'b1, rdat[SMM_FL_BUSY])
		ext_sda_n <= 1'b1;
		repeat (10) @(posedge pclk);
		apb(1'b0, CA, 0);
		`CHK("free", 1'b0, rdat[SMM_FL_BUSY])
		$display("test busy done");
		report_and_stop;
	end
endmodule : testbench
